// ==== logic/tlbm_defines.vh ====
/*
 Constants for the translation-table maintenance block: instruction
 encodings, staging register field positions, reset values.
 Assumes 32-bit staging register layouts of the system coprocessor.
*/
`ifndef TLBM_DEFINES_VH
`define TLBM_DEFINES_VH

// Instruction word fields
`define TLBM_OPC_HI          31
`define TLBM_OPC_LO          26
`define TLBM_OPC_SYSCOP      6'h10
`define TLBM_COP_FLAG_BIT    25
`define TLBM_ZERO_HI         24
`define TLBM_ZERO_LO         6
`define TLBM_FUNC_HI         5
`define TLBM_FUNC_LO         0
`define TLBM_FUNC_RD_IDX     6'h01
`define TLBM_FUNC_WR_IDX     6'h02
`define TLBM_FUNC_WR_RND     6'h06

// entry_high_reg fields
`define TLBM_VPN_HI          31
`define TLBM_VPN_LO          13
`define TLBM_ADDRESS_SPACE_ID_HI         7
`define TLBM_ADDRESS_SPACE_ID_LO         0
// Page low register fields
`define TLBM_PFN_HI          25
`define TLBM_PFN_LO          6
`define TLBM_CDV_HI          5
`define TLBM_CDV_LO          1
`define TLBM_GLOBAL_BIT      0
// page_size_mask_reg mask field
`define TLBM_MASK_HI         28
`define TLBM_MASK_LO         13

// Reset value of staging registers
`define TLBM_REG_RST         32'h00000000

`endif

// ==== logic/tlbm_entry_ram.v ====
/*
 Translation table storage: one word per entry, one write port and
 two combinational read ports (read-back and multiple-match scan).
 Assumes a single clock; write data is ready in the write cycle.
*/
`timescale 1ns/1ns
`default_nettype none

module tlbm_entry_ram #(
	parameter WIDTH     = 64,
	parameter DEPTH     = 16,
	parameter IDX_W     = 4
) (
	input  wire             clk,
	input  wire             wr_en,
	input  wire [IDX_W-1:0] wr_idx,
	input  wire [WIDTH-1:0] wr_data,
	input  wire [IDX_W-1:0] rd_idx,
	output wire [WIDTH-1:0] rd_data,
	input  wire [IDX_W-1:0] scan_idx,
	output wire [WIDTH-1:0] scan_data
);

	reg [WIDTH-1:0] mem [0:DEPTH-1];

	// Storage only: no reset, valid bits are set by every write and never cleared
	always @(posedge clk)
	begin
		if (wr_en)
			mem[wr_idx] <= wr_data;
	end

	// Async read ports
	assign rd_data   = mem[rd_idx];
	assign scan_data = mem[scan_idx];

endmodule // tlbm_entry_ram

`default_nettype wire

// ==== logic/tlbm_maint.v ====
/*
 Translation table maintenance: indexed write, random write and
 indexed read of table entries, with mask trimming, shared-bit
 combining, multiple-match check and privilege check.
 Assumes the pipeline presents each instruction for at least one edge
 with BUSY low, and that all inputs come from logic on CLK.
*/
// How it works
// - Indexed write copies four staging registers into entry at index register.
// - Indexed write decoded: opcode 010000, op flag one, zero field, function 000010.
// - Random write does the same at the entry chosen by random register.
// - Page-pair number bits under mask ones may be cleared on write.
// - Frame number bits under mask ones may be cleared on write.
// - Mask least bit lines up with page and frame number least bits.
// - Stored shared bit is AND of even and odd staging shared bits.
// - Multiple matching entries on a write raise a machine check.
// - Multiple matches reported only on writes, never on reads.
// - Without coprocessor access, signal coprocessor unusable, do nothing.
// - Indexed read with out-of-range index is undefined, not guarded.
// - Indexed read loads all four staging registers from indexed entry.
// - Read returns the single shared bit into both page low registers.
`timescale 1ns/1ns
`default_nettype none
`include "tlbm_defines.vh"

module tlbm_maint #(
	parameter ENTRIES  = 16,
	parameter IDX_W    = 4,
	parameter CLR_MASK = 1'b1
) (
	input  wire             CLK,
	input  wire             SYS_RST,
	input  wire             INSTR_VALID,
	input  wire [31:0]      INSTR_WORD,
	input  wire             SYSCOP_USABLE,
	input  wire [IDX_W-1:0] INDEX_REG,
	input  wire [IDX_W-1:0] RANDOM_REG,
	input  wire             STAGE_WR_EN,
	input  wire [31:0]      ENTRY_HIGH_IN,
	input  wire [31:0]      EVEN_LO_IN,
	input  wire [31:0]      ODD_LO_IN,
	input  wire [31:0]      MASK_IN,
	output reg  [31:0]      ENTRY_HIGH_REG,
	output reg  [31:0]      EVEN_PAGE_LO_REG,
	output reg  [31:0]      ODD_PAGE_LO_REG,
	output reg  [31:0]      PAGE_SIZE_MASK_REG,
	output reg              INSTR_DONE,
	output reg              COP_UNUSABLE,
	output reg              MACHINE_CHECK,
	output reg              BUSY
);

	// Entry word: mask 16, vpn 19, address_space_id 8, physical_frame_number_even 20, cdv0 5, physical_frame_number_odd 20, cdv1 5, g 1, valid 1
	localparam WIDTH = 95;
	localparam [4:0] ST_IDLE = 5'h01;
	localparam [4:0] ST_WR   = 5'h02;
	localparam [4:0] ST_SCAN = 5'h04;
	localparam [4:0] ST_RD   = 5'h08;
	localparam [4:0] ST_DONE = 5'h10;
	// Last scan slot kept at integer width; compared against a padded counter
	localparam LAST = ENTRIES - 1;

	reg [4:0]       state_ff;
	reg [4:0]       nxt_state;
	reg [IDX_W-1:0] slot_ff;
	reg [IDX_W-1:0] scan_ff;
	reg             multi_ff;
	wire [WIDTH-1:0] rd_data;
	wire [WIDTH-1:0] scan_data;

	// Instruction decode
	wire is_syscop = INSTR_WORD[`TLBM_OPC_HI:`TLBM_OPC_LO] == `TLBM_OPC_SYSCOP;
	wire body_ok   = INSTR_WORD[`TLBM_COP_FLAG_BIT]
		&& (INSTR_WORD[`TLBM_ZERO_HI:`TLBM_ZERO_LO] == 19'h00000);
	wire [5:0] func = INSTR_WORD[`TLBM_FUNC_HI:`TLBM_FUNC_LO];
	// Words that match none of the three are ignored, no fault raised
	wire dec_wi = is_syscop && body_ok && func == `TLBM_FUNC_WR_IDX;
	wire dec_wr = is_syscop && body_ok && func == `TLBM_FUNC_WR_RND;
	wire dec_rd = is_syscop && body_ok && func == `TLBM_FUNC_RD_IDX;
	wire dec_any = dec_wi | dec_wr | dec_rd;

	// Mask trimming, mask lsb at page-number lsb
	wire [15:0] mask   = PAGE_SIZE_MASK_REG[`TLBM_MASK_HI:`TLBM_MASK_LO];
	wire [15:0] trim   = CLR_MASK ? mask : 16'h0000;
	wire [18:0] vpn_w  = ENTRY_HIGH_REG[`TLBM_VPN_HI:`TLBM_VPN_LO] & ~{3'h0, trim};
	wire [19:0] physical_frame_number_even_w = EVEN_PAGE_LO_REG[`TLBM_PFN_HI:`TLBM_PFN_LO] & ~{4'h0, trim};
	wire [19:0] physical_frame_number_odd_w = ODD_PAGE_LO_REG[`TLBM_PFN_HI:`TLBM_PFN_LO] & ~{4'h0, trim};
	wire g_w = EVEN_PAGE_LO_REG[`TLBM_GLOBAL_BIT] & ODD_PAGE_LO_REG[`TLBM_GLOBAL_BIT];

	// Entry word built from staging registers
	wire [WIDTH-1:0] wr_word = {mask, vpn_w,
		ENTRY_HIGH_REG[`TLBM_ADDRESS_SPACE_ID_HI:`TLBM_ADDRESS_SPACE_ID_LO],
		physical_frame_number_even_w, EVEN_PAGE_LO_REG[`TLBM_CDV_HI:`TLBM_CDV_LO],
		physical_frame_number_odd_w, ODD_PAGE_LO_REG[`TLBM_CDV_HI:`TLBM_CDV_LO],
		g_w, 1'b1};

	// Fields of the scanned entry
	wire [15:0] s_mask = scan_data[94:79];
	wire [18:0] s_vpn  = scan_data[78:60];
	wire [7:0]  s_address_space_id = scan_data[59:52];
	wire        s_g    = scan_data[1];
	wire        s_ok   = scan_data[0];
	wire [18:0] cmp_m  = ~({3'h0, s_mask} | {3'h0, mask});
	// The wider of the two pages sets the compare; the slot being replaced is skipped
	wire s_hit = s_ok && scan_ff != slot_ff
		&& ((s_vpn & cmp_m) == (vpn_w & cmp_m))
		&& (s_g | g_w | s_address_space_id == ENTRY_HIGH_REG[`TLBM_ADDRESS_SPACE_ID_HI:`TLBM_ADDRESS_SPACE_ID_LO]);

	// Read-back and scan use separate read ports so a scan never blocks a read.
	// Entries never written have no defined valid bit: fill the table first.
	tlbm_entry_ram #(
		.WIDTH     (WIDTH),
		.DEPTH     (ENTRIES),
		.IDX_W     (IDX_W)
	) u_ram (
		.clk       (CLK),
		.wr_en     (state_ff == ST_WR),
		.wr_idx    (slot_ff),
		.wr_data   (wr_word),
		.rd_idx    (slot_ff),
		.rd_data   (rd_data),
		.scan_idx  (scan_ff),
		.scan_data (scan_data)
	);

	// Sequencer; scan runs before the write so a clash is seen against old contents
	always @*
	begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE:
				if (INSTR_VALID && dec_any && SYSCOP_USABLE)
					nxt_state = dec_rd ? ST_RD : ST_SCAN;
				// Without access, finish at once and leave the table alone
				else if (INSTR_VALID && dec_any)
					nxt_state = ST_DONE;
			// Scan visits every slot once, then the write follows
			ST_SCAN: if ({{(32-IDX_W){1'b0}}, scan_ff} == LAST) nxt_state = ST_WR;
			ST_WR:   nxt_state = ST_DONE;
			ST_RD:   nxt_state = ST_DONE;
			ST_DONE: nxt_state = ST_IDLE;
			default: nxt_state = ST_IDLE;
		endcase
	end

	// State, slot and match tracking
	always @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			state_ff <= ST_IDLE;
			slot_ff  <= {IDX_W{1'b0}};
			scan_ff  <= {IDX_W{1'b0}};
			multi_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			if (state_ff == ST_IDLE)
			begin
				// Index assumed in range by software; no guard
				slot_ff  <= dec_wr ? RANDOM_REG : INDEX_REG;
				scan_ff  <= {IDX_W{1'b0}};
				multi_ff <= 1'b0;
			end
			else if (state_ff == ST_SCAN)
			begin
				// Wraps to zero after the last slot; cleared on the next take anyway
				scan_ff  <= scan_ff + {{(IDX_W-1){1'b0}}, 1'b1};
				multi_ff <= multi_ff | s_hit;
			end
		end
	end

	// Staging registers, status outputs
	always @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			ENTRY_HIGH_REG     <= `TLBM_REG_RST;
			EVEN_PAGE_LO_REG   <= `TLBM_REG_RST;
			ODD_PAGE_LO_REG    <= `TLBM_REG_RST;
			PAGE_SIZE_MASK_REG <= `TLBM_REG_RST;
			INSTR_DONE         <= 1'b0;
			COP_UNUSABLE       <= 1'b0;
			MACHINE_CHECK      <= 1'b0;
			BUSY               <= 1'b0;
		end
		else
		begin
			// Pulses follow the next state so they line up with the state change
			INSTR_DONE    <= nxt_state == ST_DONE;
			BUSY          <= nxt_state != ST_IDLE;
			COP_UNUSABLE  <= state_ff == ST_IDLE && INSTR_VALID && dec_any
				&& !SYSCOP_USABLE;
			// Only the write path raises the check; reads never do
			MACHINE_CHECK <= state_ff == ST_WR && multi_ff;
			// Read trims page-pair bits again; harmless, the stored copy is trimmed
			if (state_ff == ST_RD)
			begin
				PAGE_SIZE_MASK_REG <= {3'h0, rd_data[94:79], 13'h0000};
				ENTRY_HIGH_REG     <= {rd_data[78:60] & ~{3'h0, rd_data[94:79]},
					5'h00, rd_data[59:52]};
				EVEN_PAGE_LO_REG   <= {6'h00, rd_data[51:32], rd_data[31:27],
					rd_data[1]};
				ODD_PAGE_LO_REG    <= {6'h00, rd_data[26:7], rd_data[6:2],
					rd_data[1]};
			end
			else if (STAGE_WR_EN && state_ff == ST_IDLE)
			begin
				// Loads only while idle, so a scan and its write see one image
				ENTRY_HIGH_REG     <= ENTRY_HIGH_IN;
				EVEN_PAGE_LO_REG   <= EVEN_LO_IN;
				ODD_PAGE_LO_REG    <= ODD_LO_IN;
				PAGE_SIZE_MASK_REG <= MASK_IN;
			end
		end
	end

endmodule // tlbm_maint

`default_nettype wire

// ==== tb/tlbm_props.sv ====
/*
 Checker for the table maintenance block's ports.
 Assumes a bind to tlbm_maint with sixteen entries.
*/
`timescale 1ns/1ns
`default_nettype none
module tlbm_props #(
	parameter ENTRIES = 16,
	parameter IDX_W   = 4
) (
	input wire logic        CLK,
	input wire logic        SYS_RST,
	input wire logic        INSTR_VALID,
	input wire logic [31:0] INSTR_WORD,
	input wire logic        SYSCOP_USABLE,
	input wire logic        STAGE_WR_EN,
	input wire logic [31:0] ENTRY_HIGH_REG,
	input wire logic [31:0] EVEN_PAGE_LO_REG,
	input wire logic [31:0] ODD_PAGE_LO_REG,
	input wire logic        INSTR_DONE,
	input wire logic        COP_UNUSABLE,
	input wire logic        MACHINE_CHECK,
	input wire logic        BUSY
);
	default clocking @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	// Decode of the accepted words, taken only while idle
	wire hdr  = INSTR_WORD[31:25] == 7'h21 && INSTR_WORD[24:6] == 19'h00000;
	wire take = INSTR_VALID && !BUSY;
	wire rd_w = hdr && INSTR_WORD[5:0] == 6'h01;
	wire wr_w = hdr && (INSTR_WORD[5:0] == 6'h02 || INSTR_WORD[5:0] == 6'h06);
	done_pulse_a: assert property (INSTR_DONE |=> !INSTR_DONE) else $error("done too long");
	mc_done_a: assert property (MACHINE_CHECK |-> INSTR_DONE) else $error("stray check");
	cu_done_a: assert property (COP_UNUSABLE |-> INSTR_DONE && !MACHINE_CHECK)
		else $error("stray unusable");
	cu_take_a: assert property (take && (rd_w || wr_w) && !SYSCOP_USABLE |=> COP_UNUSABLE)
		else $error("no unusable");
	rd_timing_a: assert property (take && rd_w && SYSCOP_USABLE |-> ##2 INSTR_DONE
		&& !MACHINE_CHECK && EVEN_PAGE_LO_REG[0] == ODD_PAGE_LO_REG[0]) else $error("bad read");
	wr_timing_a: assert property (take && wr_w && SYSCOP_USABLE |=> BUSY[*8] ##10 INSTR_DONE)
		else $error("bad write timing");
	stage_hold_a: assert property ($changed(ENTRY_HIGH_REG) || $changed(ODD_PAGE_LO_REG)
		|-> $past(STAGE_WR_EN) || INSTR_DONE) else $error("staging moved");
	refuse_word_a: assert property (take && !rd_w && !wr_w |=> !BUSY) else $error("took bad word");
endmodule // tlbm_props
bind tlbm_maint tlbm_props #(.ENTRIES(ENTRIES), .IDX_W(IDX_W)) u_props (.CLK(CLK),
	.SYS_RST(SYS_RST), .INSTR_VALID(INSTR_VALID), .INSTR_WORD(INSTR_WORD),
	.SYSCOP_USABLE(SYSCOP_USABLE), .STAGE_WR_EN(STAGE_WR_EN), .ENTRY_HIGH_REG(ENTRY_HIGH_REG),
	.EVEN_PAGE_LO_REG(EVEN_PAGE_LO_REG), .ODD_PAGE_LO_REG(ODD_PAGE_LO_REG),
	.INSTR_DONE(INSTR_DONE), .COP_UNUSABLE(COP_UNUSABLE), .MACHINE_CHECK(MACHINE_CHECK),
	.BUSY(BUSY));
`default_nettype wire

// ==== tb/tlbm_pipe.sv ====
/*
 Pipeline model: presents one maintenance word with its selectors.
 Assumes reset is released before the first issue.
*/
`timescale 1ns/1ns
`default_nettype none
module tlbm_pipe (
	input  wire logic        clk,
	input  wire logic        busy,
	output var  logic        valid,
	output var  logic [31:0] word,
	output var  logic [3:0]  idx,
	output var  logic [3:0]  rnd
);
	initial
	begin
		valid = 1'b0;
		{word, idx, rnd} = 40'h0000000000;
	end
	// Held until the idle edge takes it; stale values inverted after
	task automatic issue(input logic [31:0] w, input logic [3:0] ix, input logic [3:0] rx);
		@(posedge clk) #1;
		while (busy)
			@(posedge clk) #1;
		valid = 1'b1;
		{word, idx, rnd} = {w, ix, rx};
		@(posedge clk) #1;
		valid = 1'b0;
		{word, idx, rnd} = ~{w, ix, rx};
	endtask
endmodule // tlbm_pipe
`default_nettype wire

// ==== tb/tb.sv ====
/*
 Bench for table maintenance: staged writes, reads and faults.
 Assumes the pipeline model in tlbm_pipe.sv.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) \
	begin \
		tests_run++; \
		if ((got) !== (exp)) \
		begin \
			mismatches++; \
			$display("ERROR at %0t: value mismatch", $time); \
		end \
	end
module tb;
	logic        clk, sys_rst, usable, stage_en, valid, done, cu, mc, busy;
	logic [31:0] eh_in, e0_in, o0_in, m_in, word, eh_q, e0_q, o0_q, m_q;
	logic [3:0]  idx, rnd;
	int          mismatches = 0;
	int          tests_run = 0;
	int          bad;
	logic [5:0]  bad_fn [3] = '{6'h01, 6'h02, 6'h06};
	tlbm_maint #(.ENTRIES(16), .IDX_W(4), .CLR_MASK(1'b1)) DUT (.CLK(clk), .SYS_RST(sys_rst),
		.INSTR_VALID(valid), .INSTR_WORD(word), .SYSCOP_USABLE(usable), .INDEX_REG(idx),
		.RANDOM_REG(rnd), .STAGE_WR_EN(stage_en), .ENTRY_HIGH_IN(eh_in), .EVEN_LO_IN(e0_in),
		.ODD_LO_IN(o0_in), .MASK_IN(m_in), .ENTRY_HIGH_REG(eh_q), .EVEN_PAGE_LO_REG(e0_q),
		.ODD_PAGE_LO_REG(o0_q), .PAGE_SIZE_MASK_REG(m_q), .INSTR_DONE(done),
		.COP_UNUSABLE(cu), .MACHINE_CHECK(mc), .BUSY(busy));
	tlbm_pipe pipe (.clk(clk), .busy(busy), .valid(valid), .word(word), .idx(idx), .rnd(rnd));
	always #20 clk = ~clk;
	// Distinct page pairs per entry so only planted duplicates match
	function automatic logic [31:0] hi_of(int i);
		hi_of = {15'(i + 1), 4'h0, 5'h00, 8'(i * 3 + 33)};
	endfunction
	function automatic logic [31:0] lo_of(int i, bit odd, bit g);
		lo_of = {6'h00, 20'(odd ? i * 11 + 9 : i * 37 + 5), odd ? 5'(~i) : 5'(i), g};
	endfunction
	task automatic stage(logic [31:0] h, logic [31:0] e, logic [31:0] o, logic [31:0] m);
		@(posedge clk) #1;
		{eh_in, e0_in, o0_in, m_in} = {h, e, o, m};
		stage_en = 1'b1;
		@(posedge clk) #1;
		stage_en = 1'b0;
	endtask
	// Machine check skipped while entries may still be unwritten
	task automatic run(logic [5:0] fn, logic [3:0] ix, logic [3:0] rx, logic ecu, logic emc);
		pipe.issue({6'h10, 1'b1, 19'h00000, fn}, ix, rx);
		for (bad = 40; bad > 0 && done !== 1'b1; bad--)
			@(negedge clk);
		`CHK(done, 1'b1);
		`CHK(busy, 1'b1);
		`CHK(cu, ecu);
		if (emc !== 1'bx)
			`CHK(mc, emc);
	endtask
	task automatic rd(logic [3:0] ix, logic [31:0] h, logic [31:0] e, logic [31:0] o, logic [31:0] m);
		run(6'h01, ix, ~ix, 1'b0, 1'b0);
		`CHK(eh_q, h);
		`CHK(e0_q, e);
		`CHK(o0_q, o);
		`CHK(m_q, m);
	endtask
	task automatic final_report;
		$display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial
	begin
		{clk, sys_rst, usable, stage_en} = 4'h6;
		{eh_in, e0_in, o0_in, m_in} = 128'h0;
		repeat (20) @(posedge clk);
		#1 sys_rst = 1'b0;
		// Fill all entries; odd ones through the random selector
		for (int i = 0; i < 16; i++)
		begin
			stage(hi_of(i), lo_of(i, 0, i[0]), lo_of(i, 1, 1'b1), 32'h00000000);
			run(i[0] ? 6'h06 : 6'h02, 4'(i[0] ? 15 - i : i), 4'(i[0] ? i : 15 - i), 1'b0, 1'bx);
		end
		for (int i = 0; i < 16; i++)
			rd(4'(i), hi_of(i), lo_of(i, 0, i[0]), lo_of(i, 1, i[0]), 32'h00000000);
		// Larger page trims low page and frame bits
		stage(hi_of(3) | 32'h00006000, lo_of(3, 0, 1) | 32'h000000c0,
			lo_of(3, 1, 1) | 32'h000000c0, 32'h00006000);
		run(6'h02, 4'h3, 4'hc, 1'b0, 1'b0);
		rd(4'h3, hi_of(3), lo_of(3, 0, 1), lo_of(3, 1, 1) & ~32'h000000c0, 32'h00006000);
		stage(hi_of(4), lo_of(4, 0, 0), lo_of(4, 1, 1), 32'h00000000);
		run(6'h02, 4'h5, 4'h0, 1'b0, 1'b1);
		// Without access nothing is written or read
		@(posedge clk) #1;
		usable = 1'b0;
		stage(32'hffffe0ff, 32'h03ffffff, 32'h03ffffff, 32'h1fffe000);
		foreach (bad_fn[k])
			run(bad_fn[k], 4'h0, 4'h0, 1'b1, 1'b0);
		`CHK(eh_q, 32'hffffe0ff);
		`CHK(m_q, 32'h1fffe000);
		usable = 1'b1;
		rd(4'h0, hi_of(0), lo_of(0, 0, 0), lo_of(0, 1, 0), 32'h00000000);
		pipe.issue({6'h10, 1'b1, 19'h00001, 6'h02}, 4'h1, 4'h1);
		bad = 0;
		repeat (24) @(negedge clk) bad += (done !== 1'b0);
		`CHK(bad, 0);
		rd(4'h1, hi_of(1), lo_of(1, 0, 1), lo_of(1, 1, 1), 32'h00000000);
		final_report;
	end
	// Watchdog well beyond the expected several hundred cycles
	initial
	begin
		repeat (3000) @(posedge clk);
		mismatches++;
		final_report;
	end
endmodule // tb
`default_nettype wire
